// ===== include/i2ctp_params.svh
/*
 * Constants of the two-wire target register port: address base,
 * page selector location, reset values and byte framing.
 * Assumes inclusion by bare name from package or module files.
 */
`ifndef I2CTP_PARAMS_SVH
`define I2CTP_PARAMS_SVH

// 7-bit target address for strap code 0 (write byte 0xe0)
`define I2CTP_ADDR_BASE   7'h70
// Subaddress that holds the page selector on every page
`define I2CTP_PAGE_SUB    8'h00
`define I2CTP_PAGE_RST    8'h00
`define I2CTP_SUB_RST     8'h00
// Bits in one address or data byte
`define I2CTP_BYTE_BITS   4'h8
// Last bit index of a byte sent out
`define I2CTP_TX_LAST     4'h7
// Pin samples from the bus: scl, sda, then three strap bits
`define I2CTP_PIN_W       5

`endif

// ===== include/i2ctp_pkg.sv
/*
 * Types of the two-wire target register port.
 * Assumes i2ctp_params.svh is on the include path.
 */
package i2ctp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_BYTE  = 3'b101,
    ST_RD_ACK   = 3'b110
  } i2ctp_state_t;

endpackage

// ===== rtl/i2ctp_sync.sv
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes each bit is a level that stays for several destination clocks.
 */
`timescale 1ns/100ps

module i2ctp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o      <= meta_reg;
  end

endmodule // i2ctp_sync

// ===== rtl/i2ctp_port.sv
/*
 * Two-wire target port giving a host access to a paged register space.
 * The bus protocol runs on lnk_clk_i, which oversamples scl and sda;
 * register accesses are issued on sys_clk_i through a toggle handshake.
 * Assumes lnk_clk_i runs free and much faster than scl, rst_i is the
 * power-on reset held for at least four cycles of each clock, and the
 * register file answers reg_rdata_i in the cycle reg_rd_o is high.
 */
// Overview of operation
// - Strap address captured once after reset
// - Strap code selects write address 0xe0..0xee
// - Bytes are eight bits, MSB first
// - Receiver acknowledges in ninth clock
// - SDA fall/rise with SCL high: start/stop
// - Data changes only while SCL low
// - First byte: address plus direction, must match
// - Acknowledge holds SDA low whole period
// - SDA only pulled low or released
// - Transfers of any length until stop
// - Direction 0 writes; every byte acknowledged
// - Write stores byte then increments subaddress
// - Read: write subaddress, repeated start, read
// - Controller ack advances subaddress, next byte
// - Not-acknowledge makes device release SDA
// - Works at 100kHz and 400kHz
// - Subaddress 0 is the page selector
`timescale 1ns/100ps
`include "i2ctp_params.svh"

module i2ctp_port
  import i2ctp_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       lnk_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] strap_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic      [7:0] reg_page_o
);

  // Link domain
  logic                      lnk_rst;
  logic [`I2CTP_PIN_W-1:0]   pin_s;
  logic                      scl_s;
  logic                      sda_s;
  logic [2:0]                strap_s;
  logic                      scl_q_reg;
  logic                      sda_q_reg;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  logic                      strap_done_reg;
  logic [6:0]                my_addr_reg;
  i2ctp_state_t              state_reg;
  i2ctp_state_t              state_next;
  logic [3:0]                bit_cnt_reg;
  logic [7:0]                rx_reg;
  logic [7:0]                tx_reg;
  logic                      oe_reg;
  logic                      rw_reg;
  logic                      first_reg;
  logic [7:0]                sub_reg;
  logic                      byte_done;
  logic                      addr_hit;
  logic                      issue_rd;
  logic                      issue_wr;
  logic                      ctl_ack;
  logic [7:0]                issue_addr;
  logic                      req_tgl_reg;
  logic                      req_wr_reg;
  logic [7:0]                req_addr_reg;
  logic [7:0]                req_data_reg;
  logic                      ack_tgl_s;
  logic                      ack_q_reg;
  logic [7:0]                rd_hold_reg;

  // System domain
  logic                      req_tgl_s;
  logic                      req_q_reg;
  logic                      req_evt;
  logic                      ack_tgl_reg;
  logic [7:0]                rd_data_reg;

  function automatic logic is_page_sub(input logic [7:0] addr);
    is_page_sub = (addr == `I2CTP_PAGE_SUB);
  endfunction

  // Crossings: reset, pins and the toggle handshake
  i2ctp_sync #(.WIDTH(1)) u_rst_sync (.clk_i(lnk_clk_i), .d_i(rst_i), .q_o(lnk_rst));
  i2ctp_sync #(.WIDTH(`I2CTP_PIN_W)) u_pin_sync (
    .clk_i (lnk_clk_i),
    .d_i   ({strap_i, sda_i, scl_i}),
    .q_o   (pin_s)
  );
  i2ctp_sync #(.WIDTH(1)) u_req_sync (.clk_i(sys_clk_i), .d_i(req_tgl_reg), .q_o(req_tgl_s));
  i2ctp_sync #(.WIDTH(1)) u_ack_sync (.clk_i(lnk_clk_i), .d_i(ack_tgl_reg), .q_o(ack_tgl_s));

  assign scl_s   = pin_s[0];
  assign sda_s   = pin_s[1];
  assign strap_s = pin_s[4:2];

  // Bus condition detection (link domain)
  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_reg;
  assign scl_fall  = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // Strap address capture
  // capture once, hold
  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      strap_done_reg <= 1'b0;
      my_addr_reg    <= 7'h00;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      my_addr_reg    <= `I2CTP_ADDR_BASE + {4'h0, strap_s};
    end
  end

  // Protocol state machine
  assign byte_done = scl_fall && (bit_cnt_reg == `I2CTP_BYTE_BITS);
  assign addr_hit  = strap_done_reg && (rx_reg[7:1] == my_addr_reg);
  assign ctl_ack   = (state_reg == ST_RD_ACK) && scl_rise && !sda_s;

  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = ST_ADDR;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (byte_done) state_next = addr_hit ? ST_ADDR_ACK : ST_IDLE;
        end
        ST_ADDR_ACK: begin
          if (scl_fall) state_next = rw_reg ? ST_RD_BYTE : ST_WR_BYTE;
        end
        ST_WR_BYTE: begin
          if (byte_done) state_next = ST_WR_ACK;
        end
        ST_WR_ACK: begin
          if (scl_fall) state_next = ST_WR_BYTE;
        end
        ST_RD_BYTE: begin
          if (scl_fall && (bit_cnt_reg == `I2CTP_TX_LAST)) state_next = ST_RD_ACK;
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_s) begin
            state_next = ST_IDLE;
          end else if (scl_fall) begin
            state_next = ST_RD_BYTE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst || start_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (state_reg == ST_ADDR || state_reg == ST_WR_BYTE) begin
      bit_cnt_reg <= bit_cnt_reg + {3'h0, scl_rise};
    end else if (state_reg == ST_RD_BYTE) begin
      bit_cnt_reg <= bit_cnt_reg + {3'h0, scl_fall};
    end else if (scl_fall) begin
      bit_cnt_reg <= 4'h0;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      rx_reg <= 8'h00;
    end else if (scl_rise && (state_reg == ST_ADDR || state_reg == ST_WR_BYTE)) begin
      rx_reg <= {rx_reg[6:0], sda_s};
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      rw_reg <= 1'b0;
    end else if (byte_done && state_reg == ST_ADDR) begin
      rw_reg <= rx_reg[0];
    end
  end

  // SDA drive; updated on scl falling edges, also cleared on start, stop or a nack
  // change while SCL low
  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst || start_det || stop_det) begin
      oe_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          oe_reg <= byte_done && addr_hit;
        end
        ST_ADDR_ACK: begin
          if (rw_reg) begin
            tx_reg <= rd_hold_reg;
            oe_reg <= ~rd_hold_reg[7];
          end else begin
            oe_reg <= 1'b0;
          end
        end
        ST_WR_BYTE: begin
          oe_reg <= byte_done;
        end
        ST_RD_BYTE: begin
          if (bit_cnt_reg == `I2CTP_TX_LAST) begin
            oe_reg <= 1'b0;
          end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            oe_reg <= ~tx_reg[6];
          end
        end
        ST_RD_ACK: begin
          tx_reg <= rd_hold_reg;
          oe_reg <= ~rd_hold_reg[7];
        end
        default: begin
          oe_reg <= 1'b0;
        end
      endcase
    end else if (state_reg == ST_RD_ACK && scl_rise && sda_s) begin
      oe_reg <= 1'b0;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_reg;

  // Subaddress tracking and access requests
  assign issue_rd = (byte_done && state_reg == ST_ADDR && addr_hit && rx_reg[0])
                    || ctl_ack;
  assign issue_wr = byte_done && state_reg == ST_WR_BYTE && !first_reg;
  assign issue_addr = ctl_ack ? sub_reg + 8'h01 : sub_reg;

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst || start_det) begin
      first_reg <= 1'b1;
    end else if (byte_done && state_reg == ST_WR_BYTE) begin
      first_reg <= 1'b0;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      sub_reg <= `I2CTP_SUB_RST;
    end else if (byte_done && state_reg == ST_WR_BYTE && first_reg) begin
      sub_reg <= rx_reg;
    end else if (issue_wr || ctl_ack) begin
      sub_reg <= sub_reg + 8'h01;
    end
  end

  // Bundle stays stable until the next toggle
  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      req_tgl_reg  <= 1'b0;
      req_wr_reg   <= 1'b0;
      req_addr_reg <= 8'h00;
      req_data_reg <= 8'h00;
    end else if (issue_rd || issue_wr) begin
      req_tgl_reg  <= ~req_tgl_reg;
      req_wr_reg   <= issue_wr;
      req_addr_reg <= issue_addr;
      req_data_reg <= rx_reg;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (lnk_rst) begin
      ack_q_reg   <= 1'b0;
      rd_hold_reg <= 8'h00;
    end else begin
      ack_q_reg <= ack_tgl_s;
      if (ack_tgl_s != ack_q_reg) begin
        rd_hold_reg <= rd_data_reg;
      end
    end
  end

  // Register side (system domain)
  assign req_evt = req_tgl_s ^ req_q_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_q_reg   <= 1'b0;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      reg_addr_o  <= 8'h00;
      reg_wdata_o <= 8'h00;
    end else begin
      req_q_reg <= req_tgl_s;
      reg_wr_o  <= req_evt && req_wr_reg && !is_page_sub(req_addr_reg);
      reg_rd_o  <= req_evt && !req_wr_reg;
      if (req_evt) begin
        reg_addr_o  <= req_addr_reg;
        reg_wdata_o <= req_data_reg;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_page_o <= `I2CTP_PAGE_RST;
    end else if (req_evt && req_wr_reg && is_page_sub(req_addr_reg)) begin
      reg_page_o <= req_data_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_reg <= 8'h00;
      ack_tgl_reg <= 1'b0;
    end else if (reg_rd_o) begin
      rd_data_reg <= is_page_sub(reg_addr_o) ? reg_page_o : reg_rdata_i;
      ack_tgl_reg <= ~ack_tgl_reg;
    end
  end

endmodule // i2ctp_port

// ===== sim/i2ctp_ctrl_model.sv
/* Two-wire bus controller model: drives scl and its share of sda.
   Assumes the bench resolves sda with a pull-up and the target's drive. */
`timescale 1ns/100ps

module i2ctp_ctrl_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  int h = 1250;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #(h / 2);
    scl_o = 1'b1;
    #(h / 2);
    r = sda_i;
    #(h / 2);
    scl_o = 1'b0;
    #(h / 2);
  endtask

  task automatic start();
    sda_o = 1'b1;
    #(h / 2);
    scl_o = 1'b1;
    #(h / 2);
    sda_o = 1'b0;
    #(h / 2);
    scl_o = 1'b0;
    #(h / 2);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #(h / 2);
    scl_o = 1'b1;
    #(h / 2);
    sda_o = 1'b1;
    #h;
  endtask

  // msb first, ack in ninth clock
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // ack asks for more, nack ends
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // i2ctp_ctrl_model

// ===== sim/i2ctp_port_properties.sv
/* Concurrent checks on the target port's bus drive and register strobes.
   Assumes a bind to i2ctp_port; scl_i is the raw bus clock level. */
`timescale 1ns/100ps

module i2ctp_port_properties (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       lnk_clk_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       reg_wr_o,
  input wire logic       reg_rd_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic [7:0] reg_page_o
);
  sda_low_only_a: assert property (@(posedge lnk_clk_i) disable iff (rst_i)
    sda_o == 1'b0) else $error("sda driven high");
  oe_scl_low_a: assert property (@(posedge lnk_clk_i) disable iff (rst_i)
    $changed(sda_oe_o) |-> !scl_i) else $error("sda drive moved with scl high");
  ack_hold_a: assert property (@(posedge lnk_clk_i) disable iff (rst_i)
    $rose(sda_oe_o) |=> sda_oe_o [*8]) else $error("sda low drive too short");
  wr_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_wr_o |=> !reg_wr_o) else $error("write strobe longer than a cycle");
  rd_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_o |=> !reg_rd_o) else $error("read strobe longer than a cycle");
  wr_rd_excl_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(reg_wr_o && reg_rd_o)) else $error("read and write together");
  page_no_wr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_wr_o |-> reg_addr_o != 8'h00) else $error("write strobe at page selector");
  page_src_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(reg_page_o) |-> ##[0:1] reg_addr_o == 8'h00) else $error("page moved");

  cover property (@(posedge sys_clk_i) reg_wr_o);
  cover property (@(posedge sys_clk_i) reg_rd_o);
  cover property (@(posedge sys_clk_i) $changed(reg_page_o));
endmodule // i2ctp_port_properties

bind i2ctp_port i2ctp_port_properties i_i2ctp_port_properties (
  .sys_clk_i  (sys_clk_i),
  .rst_i      (rst_i),
  .lnk_clk_i  (lnk_clk_i),
  .scl_i      (scl_i),
  .sda_o      (sda_o),
  .sda_oe_o   (sda_oe_o),
  .reg_wr_o   (reg_wr_o),
  .reg_rd_o   (reg_rd_o),
  .reg_addr_o (reg_addr_o),
  .reg_page_o (reg_page_o)
);

// ===== sim/tb_i2ctp_port.sv
/* Self-checking bench for the two-wire target register port.
   Assumes the controller model and the checker bind are compiled first. */
`timescale 1ns/100ps

module tb_i2ctp_port;
  logic        sys_clk = 1'b0;
  logic        lnk_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [2:0]  strap;
  logic        scl, sda_c, sda_o, sda_oe, reg_wr, reg_rd, ack;
  logic [7:0]  reg_addr, reg_wdata, reg_page, reg_rdata, wa, pg, d;
  wire         sda = sda_c & (sda_oe ? sda_o : 1'b1);
  logic [23:0] exp_wr[$];
  logic [15:0] exp_rd[$];
  int          hp[2] = '{1250, 5000};
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #25 sys_clk = ~sys_clk;
  initial begin
    #1.3;
    forever #6 lnk_clk = ~lnk_clk;
  end
  // Register file stand-in
  assign reg_rdata = reg_addr ^ 8'h5c;

  i2ctp_port i_i2ctp_port (
    .sys_clk_i(sys_clk), .rst_i(rst), .lnk_clk_i(lnk_clk), .scl_i(scl), .sda_i(sda),
    .strap_i(strap), .reg_rdata_i(reg_rdata), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_page_o(reg_page)
  );
  i2ctp_ctrl_model i_i2ctp_ctrl_model (.sda_i(sda), .scl_o(scl), .sda_o(sda_c));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({23'h0, got}, {23'h0, exp});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr_byte(input logic [7:0] b);
    i_i2ctp_ctrl_model.put_byte(b, ack);
    chk_bit(ack, 1'b1);
  endtask

  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    if (reg_wr === 1'b1) begin
      chk({reg_page, reg_addr, reg_wdata}, exp_wr.size() ? exp_wr.pop_front() : 'x);
    end
    if (reg_rd === 1'b1) begin
      chk({8'h0, reg_page, reg_addr}, exp_rd.size() ? {8'h0, exp_rd.pop_front()} : 'x);
    end
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h9317));
    strap = 3'($urandom);
    wa = {4'he, strap, 1'b0};
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
    strap = strap + 3'h1;
    foreach (hp[k]) begin
      i_i2ctp_ctrl_model.h = hp[k];
      i_i2ctp_ctrl_model.start();
      i_i2ctp_ctrl_model.put_byte({4'he, strap, 1'b0}, ack);
      chk_bit(ack, 1'b0);
      i_i2ctp_ctrl_model.stop();
      pg = 8'($urandom);
      d = 8'($urandom);
      i_i2ctp_ctrl_model.start();
      wr_byte(wa);
      wr_byte(8'h00);
      wr_byte(pg);
      for (int i = 1; i < 3; i++) begin
        exp_wr.push_back({pg, 8'(i), d + 8'(i)});
        wr_byte(d + 8'(i));
      end
      i_i2ctp_ctrl_model.stop();
      repeat (20) @(negedge sys_clk);
      chk({16'h0, reg_page}, {16'h0, pg});
      chk(24'(exp_wr.size()), 24'h0);
      i_i2ctp_ctrl_model.start();
      wr_byte(wa);
      wr_byte(8'hff);
      i_i2ctp_ctrl_model.start();
      for (int i = 0; i < 3; i++) exp_rd.push_back({pg, 8'hff + 8'(i)});
      wr_byte(wa | 8'h01);
      for (int i = 0; i < 3; i++) begin
        i_i2ctp_ctrl_model.get_byte(i == 2, d);
        chk({16'h0, d}, {16'h0, i == 1 ? pg : (8'hff + 8'(i)) ^ 8'h5c});
      end
      chk_bit(sda_oe, 1'b0);
      i_i2ctp_ctrl_model.stop();
      chk(24'(exp_rd.size()), 24'h0);
    end
    // Second power-on reset takes the new strap code
    repeat (2) @(negedge sys_clk);
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
    i_i2ctp_ctrl_model.start();
    wr_byte({4'he, strap, 1'b0});
    i_i2ctp_ctrl_model.stop();
    chk({16'h0, reg_page}, 24'h0);
    results();
  end
endmodule // tb_i2ctp_port
